//--- verilog/smc_pkg.sv
package smc_pkg;

   localparam int          GROUP_BYTES = 6;
   localparam logic [14:0] PEC_SEED    = 15'h0010;
   localparam logic [14:0] PEC_POLY    = 15'h4599;
   localparam logic [10:0] POLL_CODE   = 11'h714;

   typedef enum logic [2:0] {
      SMC_IDLE   = 3'h0,
      SMC_CMD    = 3'h1,
      SMC_KIND   = 3'h3,
      SMC_DATA   = 3'h2,
      SMC_POLL   = 3'h6,
      SMC_IGNORE = 3'h4
   } smc_state_t;

   typedef struct packed {
      logic [10:0] code;
      logic        broadcast;
   } smc_cmd_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } smc_byte_t;

   typedef struct packed {
      logic       valid;
      logic       level;
   } smc_reply_t;

   function automatic logic [14:0] smc_pec_step(input logic [14:0] packet_check_code, input logic din);
      logic in0;
      in0 = din ^ packet_check_code[14];
      return {packet_check_code[13:0], 1'b0} ^ (in0 ? PEC_POLY : 15'h0000);
   endfunction

   function automatic logic [15:0] smc_pec16(input logic [15:0] d);
      logic [14:0] p;
      p = PEC_SEED;
      for (int i = 15; i >= 0; i--) begin
         p = smc_pec_step(p, d[i]);
      end
      return {p, 1'b0};
   endfunction

   function automatic logic [15:0] smc_pec_group(input logic [8*GROUP_BYTES-1:0] d);
      logic [14:0] p;
      p = PEC_SEED;
      for (int i = 8*GROUP_BYTES-1; i >= 0; i--) begin
         p = smc_pec_step(p, d[i]);
      end
      return {p, 1'b0};
   endfunction

   function automatic logic [2:0] smc_gray_next(input logic [2:0] g);
      logic [2:0] b;
      b[2] = g[2];
      b[1] = g[2] ^ g[1];
      b[0] = g[2] ^ g[1] ^ g[0];
      b = b + 3'h1;
      return b ^ {1'b0, b[2:1]};
   endfunction

endpackage

//--- verilog/smc_frontend.sv
`timescale 1ns/1ps
module smc_frontend #(
   parameter bit ADDRESSED = 1'b1
) (
   input  wire logic                                 clk_sys,
   input  wire logic                                 rst_n,
   input  wire logic                                 serial_clock_in,
   input  wire logic                                 chip_select_bar,
   input  wire logic                                 serial_data_in,
   input  wire logic                                 isolation_mode_select,
   input  wire logic [3:0]                           address_pin_bits,
   input  wire logic                                 conversion_busy,
   input  wire logic                                 chain_busy_in,
   input  wire logic                                 cmd_is_read,
   input  wire logic                                 cmd_is_write,
   input  wire logic [8*smc_pkg::GROUP_BYTES-1:0]    read_data,
   input  wire smc_pkg::smc_byte_t                   chain_down,
   output logic                                      serial_data_out,
   output smc_pkg::smc_reply_t                       iso_reply,
   output logic                                      cmd_valid,
   output smc_pkg::smc_cmd_t                         cmd,
   output logic                                      conv_start,
   output logic                                      write_commit,
   output logic [8*smc_pkg::GROUP_BYTES-1:0]         write_data,
   output smc_pkg::smc_byte_t                        chain_up
);

   localparam int GB = smc_pkg::GROUP_BYTES;
   localparam int WB = 8 * (GB + 2);
   localparam logic [4:0] FULL_CNT = 5'(GB + 2);

   // ******************************************************************
   // Link clock side: bit capture
   // ******************************************************************
   // Chip select high clears the bit counter, which is zero anyway at a
   // byte boundary, so the Gray count seen by the system side never jumps.

   typedef struct packed {
      logic [2:0] gray;
      logic [7:0] shift;
      logic [7:0] hold;
   } smc_link_t;

   smc_link_t lk;
   smc_link_t next_lk;

   always_comb begin
      next_lk       = lk;
      next_lk.shift = {lk.shift[6:0], serial_data_in};
      next_lk.gray  = smc_pkg::smc_gray_next(lk.gray);
      if (lk.gray == 3'h4) begin
         next_lk.hold = {lk.shift[6:0], serial_data_in};
      end
   end

   always_ff @(posedge serial_clock_in or posedge chip_select_bar) begin
      if (chip_select_bar) begin
         lk <= '0;
      end else begin
         lk <= next_lk;
      end
   end

   // ******************************************************************
   // System clock side: framing, polling and data phases
   // ******************************************************************

   typedef struct packed {
      smc_pkg::smc_state_t state;
      logic [2:0]          cs_s;
      logic [1:0]          iso_s;
      logic [3:0]          adr_s1;
      logic [3:0]          adr_s2;
      logic [2:0]          gr_s1;
      logic [2:0]          gr_s2;
      logic [2:0]          gr_s3;
      logic [4:0]          cnt;
      logic [31:0]         hdr;
      logic                is_read;
      logic                is_write;
      logic [WB-1:0]       win;
      logic [7:0]          tx;
      logic [3:0]          out_idx;
      logic [7:0]          down_hold;
      logic                down_full;
      smc_pkg::smc_cmd_t   cmd;
      logic                cmd_valid;
      logic                conv_start;
      logic                write_commit;
      logic [8*GB-1:0]     wr_data;
      smc_pkg::smc_byte_t  up;
      logic                sdo;
      smc_pkg::smc_reply_t reply;
   } smc_sys_t;

   localparam smc_sys_t SYS_RESET = '{
      state:     smc_pkg::SMC_IDLE,
      cs_s:      3'h7,
      sdo:       1'b1,
      default:   '0
   };

   smc_sys_t st;
   smc_sys_t next_st;

   logic            bit_evt;
   logic            byte_evt;
   logic            cs_rise;
   logic            busy_any;
   logic [31:0]     hdr_new;
   logic [WB-1:0]   win_new;
   logic            hdr_pec_ok;
   logic            hdr_bcast;
   logic            hdr_addr_ok;
   logic            win_pec_ok;
   logic [15:0]     rd_pec;
   logic [8*GB-1:0] rd_seq;
   logic [7:0]      rd_byte;

   assign bit_evt   = st.gr_s2 != st.gr_s3;
   assign byte_evt  = bit_evt && (st.gr_s2 == 3'h0);
   assign cs_rise   = st.cs_s[1] && !st.cs_s[2];
   // A parallel device sees only its own converter; a chained one also
   // waits for the device above, so the bottom output covers the stack.
   assign busy_any  = conversion_busy || (!ADDRESSED && chain_busy_in);

   assign hdr_new     = {st.hdr[23:0], lk.hold};
   assign win_new     = {st.win[WB-9:0], lk.hold};
   assign hdr_pec_ok  = smc_pkg::smc_pec16(hdr_new[31:16]) == hdr_new[15:0];
   assign hdr_bcast   = hdr_new[31:27] == 5'h00;
   assign hdr_addr_ok = ADDRESSED && hdr_new[31] && (hdr_new[30:27] == st.adr_s2);
   assign win_pec_ok  = smc_pkg::smc_pec_group(st.win[WB-1:16]) == st.win[15:0];
   // The lowest byte leaves first, so the check code must see it first as well.
   for (genvar i = 0; i < GB; i++) begin : g_rd_seq
      assign rd_seq[8*(GB-1-i) +: 8] = read_data[8*i +: 8];
   end
   assign rd_pec      = smc_pkg::smc_pec_group(rd_seq);

   always_comb begin
      if (st.out_idx < 4'(GB)) begin
         rd_byte = read_data[8*st.out_idx +: 8];
      end else if (st.out_idx == 4'(GB)) begin
         rd_byte = rd_pec[15:8];
      end else if (st.out_idx == 4'(GB + 1)) begin
         rd_byte = rd_pec[7:0];
      end else if (st.cmd.broadcast && st.down_full) begin
         rd_byte = st.down_hold;
      end else begin
         rd_byte = 8'hFF;
      end
   end

   always_comb begin
      next_st              = st;
      next_st.cs_s         = {st.cs_s[1:0], chip_select_bar};
      next_st.iso_s        = {st.iso_s[0], isolation_mode_select};
      next_st.adr_s1       = address_pin_bits;
      next_st.adr_s2       = st.adr_s1;
      next_st.gr_s1        = lk.gray;
      next_st.gr_s2        = st.gr_s1;
      next_st.gr_s3        = st.gr_s2;
      next_st.cmd_valid    = 1'b0;
      next_st.conv_start   = 1'b0;
      next_st.write_commit = 1'b0;
      next_st.up.valid     = 1'b0;
      next_st.reply.valid  = 1'b0;
      if (chain_down.valid) begin
         next_st.down_hold = chain_down.data;
         next_st.down_full = 1'b1;
      end
      if (st.cs_s[1]) begin
         next_st.state = smc_pkg::SMC_IDLE;
         next_st.sdo   = 1'b1;
         if (cs_rise && st.state == smc_pkg::SMC_DATA && st.is_write && win_pec_ok &&
             (st.cmd.broadcast ? st.cnt >= FULL_CNT : st.cnt == FULL_CNT)) begin
            next_st.write_commit = 1'b1;
            next_st.wr_data      = st.win[WB-1:16];
         end
      end else begin
         unique case (st.state)
            smc_pkg::SMC_IDLE: begin
               next_st.state = smc_pkg::SMC_CMD;
               next_st.cnt   = '0;
            end
            smc_pkg::SMC_CMD: begin
               if (byte_evt) begin
                  next_st.hdr = hdr_new;
                  next_st.cnt = st.cnt + 5'h01;
                  if (st.cnt == 5'h03) begin
                     next_st.cnt = '0;
                     // Wrong address or a bad check code leaves the device mute.
                     if (hdr_pec_ok && (hdr_bcast || hdr_addr_ok)) begin
                        next_st.state         = smc_pkg::SMC_KIND;
                        next_st.cmd_valid     = 1'b1;
                        next_st.cmd.code      = {hdr_new[26:24], hdr_new[23:16]};
                        next_st.cmd.broadcast = hdr_bcast;
                     end else begin
                        next_st.state = smc_pkg::SMC_IGNORE;
                     end
                  end
               end
            end
            smc_pkg::SMC_KIND: begin
               next_st.is_read  = cmd_is_read;
               next_st.is_write = cmd_is_write;
               next_st.out_idx  = '0;
               if (st.cmd.code == smc_pkg::POLL_CODE) begin
                  next_st.state = smc_pkg::SMC_POLL;
               end else if (st.cmd.code[10] ^ st.cmd.code[9]) begin
                  next_st.state      = smc_pkg::SMC_POLL;
                  next_st.conv_start = 1'b1;
               end else if (cmd_is_read || cmd_is_write) begin
                  next_st.state = smc_pkg::SMC_DATA;
                  next_st.tx    = cmd_is_read ? read_data[7:0] : 8'hFF;
                  next_st.sdo   = cmd_is_read ? read_data[7] : 1'b1;
                  if (cmd_is_read) begin
                     next_st.out_idx = 4'h1;
                  end
               end else begin
                  next_st.state = smc_pkg::SMC_IGNORE;
               end
            end
            smc_pkg::SMC_DATA: begin
               if (byte_evt) begin
                  next_st.win = win_new;
                  if (st.cnt != 5'h1F) begin
                     next_st.cnt = st.cnt + 5'h01;
                  end
                  // Bytes pushed out of the window belong to devices above.
                  if (st.is_write && st.cmd.broadcast && st.cnt >= FULL_CNT) begin
                     next_st.up.valid = 1'b1;
                     next_st.up.data  = st.win[WB-1 -: 8];
                  end
                  if (st.is_read) begin
                     next_st.tx  = rd_byte;
                     next_st.sdo = rd_byte[7];
                     if (st.out_idx > 4'(GB + 1)) begin
                        next_st.down_full = chain_down.valid;
                     end
                     if (st.out_idx != 4'hF) begin
                        next_st.out_idx = st.out_idx + 4'h1;
                     end
                  end
               end else if (bit_evt && st.is_read) begin
                  next_st.tx  = {st.tx[6:0], 1'b1};
                  next_st.sdo = st.tx[6];
               end
            end
            smc_pkg::SMC_POLL: begin
               if (st.iso_s[1]) begin
                  next_st.sdo = 1'b1;
                  if (bit_evt) begin
                     next_st.reply.valid = 1'b1;
                     next_st.reply.level = !busy_any;
                  end
               end else begin
                  next_st.sdo = !busy_any;
               end
            end
            smc_pkg::SMC_IGNORE: begin
               next_st.sdo = 1'b1;
            end
            default: begin
               next_st.state = smc_pkg::SMC_IGNORE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= SYS_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign serial_data_out = st.sdo;
   assign iso_reply       = st.reply;
   assign cmd_valid       = st.cmd_valid;
   assign cmd             = st.cmd;
   assign conv_start      = st.conv_start;
   assign write_commit    = st.write_commit;
   assign write_data      = st.wr_data;
   assign chain_up        = st.up;

   // ******************************************************************
   // Checks
   // ******************************************************************

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_header_done;
      st.state == smc_pkg::SMC_CMD && !st.cs_s[1] && byte_evt && st.cnt == 5'h03;
   endsequence

   sequence s_header_bad;
      s_header_done ##0 !hdr_pec_ok;
   endsequence

   cs_high_release_a: assert property (st.cs_s[1] |=> serial_data_out)
      else $error("data output not released after chip select high");

   header_accept_a: assert property (s_header_done |=> (cmd_valid || st.state == smc_pkg::SMC_IGNORE))
      else $error("command header neither accepted nor ignored");

   bad_check_mute_a: assert property (s_header_bad |=> !cmd_valid ##1 !conv_start)
      else $error("command with bad check code was acted on");

   addr_match_a: assert property (cmd_valid && !cmd.broadcast |-> ADDRESSED && st.hdr[30:27] == st.adr_s2)
      else $error("addressed command accepted with wrong address");

   chained_bcast_a: assert property (cmd_valid |-> ADDRESSED || cmd.broadcast)
      else $error("chained device accepted an addressed command");

   conv_follows_cmd_a: assert property (conv_start |-> $past(cmd_valid) && (cmd.code[10] ^ cmd.code[9]))
      else $error("conversion start without a conversion command");

   poll_busy_low_a: assert property (st.state == smc_pkg::SMC_POLL && !st.cs_s[1] && !st.iso_s[1] && conversion_busy
                                     |=> !serial_data_out)
      else $error("data output not low while busy in polling");

   reply_on_pulse_a: assert property (iso_reply.valid |-> $past(bit_evt) && $past(st.state) == smc_pkg::SMC_POLL)
      else $error("isolated reply without a host pulse");

   commit_on_rise_a: assert property (write_commit |-> $past(cs_rise) && $past(st.is_write))
      else $error("write committed away from chip select rising edge");

   ignore_silent_a: assert property (st.state == smc_pkg::SMC_IGNORE |-> serial_data_out && !iso_reply.valid)
      else $error("ignoring device drives status");

endmodule

//--- tb/smc_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host side of the serial link
// ****************************************
module smc_host_model (
   output logic      serial_clock_in,
   output logic      chip_select_bar,
   output logic      serial_data_in,
   input  wire logic sdo_a,
   input  wire logic sdo_b
);
   logic [7:0] tx   [24];
   logic [7:0] rx_a [24];
   logic [7:0] rx_b [24];

   initial begin
      serial_clock_in = 1'b0;
      chip_select_bar = 1'b1;
      serial_data_in  = 1'b1;
   end

   task automatic start();
      chip_select_bar = 1'b0;
      #30;
   endtask

   // The clock only runs inside frames; a 30 ns period leaves the device time to settle its output.
   task automatic xfer(input int n);
      for (int i = 0; i < n; i++) begin
         for (int b = 7; b >= 0; b--) begin
            serial_data_in = tx[i][b];
            #15;
            rx_a[i][b] = sdo_a;
            rx_b[i][b] = sdo_b;
            serial_clock_in = 1'b1;
            #15;
            serial_clock_in = 1'b0;
         end
      end
   endtask

   // The data line is not held at its last value once the frame is over.
   task automatic stop();
      #15;
      chip_select_bar = 1'b1;
      serial_data_in = ~serial_data_in;
      #60;
   endtask
endmodule

//--- tb/tb_stack_monitor_command_framing.sv
`timescale 1ns/1ps
module tb_stack_monitor_command_framing;
   localparam logic [10:0] WR_CODE = 11'h001;
   localparam logic [10:0] RD_CODE = 11'h002;
   logic                clk_sys = 1'b0;
   logic                rst_n = 1'b0;
   logic                serial_clock_in, chip_select_bar, serial_data_in;
   logic                isolation_mode_select = 1'b0;
   logic [3:0]          address_pin_bits = 4'h0;
   logic                conversion_busy = 1'b0;
   logic                chain_busy_in = 1'b0;
   logic [47:0]         read_data = 48'h0;
   smc_pkg::smc_byte_t  chain_down = '0;
   logic                sdo_a, sdo_b, cv_a, cv_b, cs_a, cs_b, wc_a, wc_b;
   smc_pkg::smc_reply_t iso_a, iso_b;
   smc_pkg::smc_cmd_t   cmd_a, cmd_b;
   logic [47:0]         wd_a, wd_b;
   smc_pkg::smc_byte_t  up_a, up_b;
   int                  bad_count = 0;
   int                  compares = 0;
   int                  n_cv_a = 0, n_cv_b = 0, n_cs_a = 0, n_cs_b = 0, n_wc_a = 0, n_wc_b = 0, n_iso = 0, n_low = 0;
   int                  n_isb = 0, n_upa = 0;
   logic [7:0]          ups [$];
   wire                 wr_a = (cmd_a.code == WR_CODE);
   wire                 rd_a = (cmd_a.code == RD_CODE);
   wire                 wr_b = (cmd_b.code == WR_CODE);
   wire                 rd_b = (cmd_b.code == RD_CODE);

   always #2.5 clk_sys = ~clk_sys;

   smc_host_model host (.serial_clock_in(serial_clock_in), .chip_select_bar(chip_select_bar),
      .serial_data_in(serial_data_in), .sdo_a(sdo_a), .sdo_b(sdo_b));
   smc_frontend #(.ADDRESSED(1'b1)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_clock_in(serial_clock_in),
      .chip_select_bar(chip_select_bar), .serial_data_in(serial_data_in), .isolation_mode_select(isolation_mode_select),
      .address_pin_bits(address_pin_bits), .conversion_busy(conversion_busy), .chain_busy_in(chain_busy_in),
      .cmd_is_read(rd_a), .cmd_is_write(wr_a), .read_data(read_data), .chain_down(chain_down),
      .serial_data_out(sdo_a), .iso_reply(iso_a), .cmd_valid(cv_a), .cmd(cmd_a), .conv_start(cs_a),
      .write_commit(wc_a), .write_data(wd_a), .chain_up(up_a));
   smc_frontend #(.ADDRESSED(1'b0)) uut_chain (.clk_sys(clk_sys), .rst_n(rst_n), .serial_clock_in(serial_clock_in),
      .chip_select_bar(chip_select_bar), .serial_data_in(serial_data_in), .isolation_mode_select(isolation_mode_select),
      .address_pin_bits(address_pin_bits), .conversion_busy(conversion_busy), .chain_busy_in(chain_busy_in),
      .cmd_is_read(rd_b), .cmd_is_write(wr_b), .read_data(read_data), .chain_down(chain_down),
      .serial_data_out(sdo_b), .iso_reply(iso_b), .cmd_valid(cv_b), .cmd(cmd_b), .conv_start(cs_b),
      .write_commit(wc_b), .write_data(wd_b), .chain_up(up_b));

   always @(negedge clk_sys) begin
      n_isb += (iso_b.valid === 1'b1);
      n_upa += (up_a.valid === 1'b1);
      n_cv_a += (cv_a === 1'b1);
      n_cv_b += (cv_b === 1'b1);
      n_cs_a += (cs_a === 1'b1);
      n_cs_b += (cs_b === 1'b1);
      n_wc_a += (wc_a === 1'b1);
      n_wc_b += (wc_b === 1'b1);
      n_iso += (iso_a.valid === 1'b1);
      n_low += (iso_a.valid === 1'b1 && iso_a.level === 1'b0);
      if (up_b.valid === 1'b1) ups.push_back(up_b.data);
   end

   // ****************************************
   // Expectations and shared steps
   // ****************************************
   function automatic logic [15:0] pec_of(input logic [7:0] d [24], input int s, input int n);
      logic [14:0] p;
      logic        in0;
      p = 15'h0010;
      for (int i = s; i < s + n; i++) begin
         for (int b = 7; b >= 0; b--) begin
            in0 = d[i][b] ^ p[14];
            p = {p[13:0], 1'b0} ^ (in0 ? 15'h4599 : 15'h0000);
         end
      end
      return {p, 1'b0};
   endfunction

   function automatic logic [47:0] pack6(input logic [7:0] d [24], input int s);
      logic [47:0] r;
      for (int i = 0; i < 6; i++) r[8*i +: 8] = d[s + i];
      return r;
   endfunction

   // Written data is held with the first byte received in the top bits.
   function automatic logic [47:0] packw(input logic [7:0] d [24], input int s);
      return {d[s], d[s + 1], d[s + 2], d[s + 3], d[s + 4], d[s + 5]};
   endfunction

   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic fill(input int s);
      logic [15:0] p;
      for (int i = s; i < s + 6; i++) host.tx[i] = 8'($urandom);
      p = pec_of(host.tx, s, 6);
      host.tx[s + 6] = p[15:8];
      host.tx[s + 7] = p[7:0];
   endtask

   task automatic run(input logic [4:0] top, input logic [10:0] code, input int nd, input bit good);
      logic [15:0] p;
      host.tx[0] = {top, code[10:8]};
      host.tx[1] = code[7:0];
      p = pec_of(host.tx, 0, 2);
      host.tx[2] = p[15:8];
      host.tx[3] = p[7:0] ^ {6'h00, ~good, 1'b0};
      host.start();
      host.xfer(4 + nd);
      repeat (12) @(posedge clk_sys);
   endtask

   task automatic drive(input logic own, input logic chain, input logic iso);
      @(negedge clk_sys);
      conversion_busy <= own;
      chain_busy_in <= chain;
      isolation_mode_select <= iso;
      repeat (6) @(posedge clk_sys);
   endtask

   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int          k0, k1, k2, k3;
      logic [10:0] code;
      logic [3:0]  other;
      logic [47:0] exp;
      logic [7:0]  ex [24];
      logic [7:0]  held;
      void'($urandom(28482));
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("reset sdo", sdo_a, 1'b1);
      check("reset wd", wd_a, 48'h0);
      for (int k = 0; k < 10; k++) begin
         @(negedge clk_sys);
         address_pin_bits = 4'($urandom);
         conversion_busy <= 1'($urandom);
         chain_busy_in <= 1'($urandom);
         isolation_mode_select <= 1'($urandom);
         code = {2'b11, 9'($urandom)};
         other = address_pin_bits ^ (4'h1 << (k % 4));
         k0 = n_cv_a;
         k1 = n_cv_b;
         case (k % 5)
            0: run(5'h00, code, 0, 1'b1);
            1: run({1'b1, address_pin_bits}, code, 0, 1'b1);
            2: run({1'b1, other}, code, 0, 1'b1);
            3: run(5'h00, code, 0, 1'b0);
            default: run({2'b01, 3'($urandom)}, code, 0, 1'b1);
         endcase
         host.stop();
         check("accept parallel", n_cv_a - k0, (k % 5) < 2);
         check("accept chained", n_cv_b - k1, (k % 5) == 0);
         if ((k % 5) < 2) check("code", {cmd_a.broadcast, cmd_a.code}, {k % 5 == 0, code});
      end
      drive(1'b1, 1'b0, 1'b0);
      run(5'h00, smc_pkg::POLL_CODE, 0, 1'b1);
      host.xfer(1);
      check("poll busy", {host.rx_a[0], host.rx_b[0]}, 16'h0000);
      drive(1'b0, 1'b1, 1'b0);
      host.xfer(2);
      check("own status", {host.rx_a[1], host.rx_b[1]}, 16'hFF00);
      drive(1'b0, 1'b0, 1'b0);
      host.xfer(2);
      check("stack done", host.rx_b[1], 8'hFF);
      drive(1'b1, 1'b0, 1'b0);
      host.xfer(1);
      host.stop();
      check("release", {sdo_a, sdo_b}, 2'b11);
      k0 = n_cs_a;
      k1 = n_cs_b;
      run(5'h00, {2'b01, 9'($urandom)}, 0, 1'b1);
      host.xfer(1);
      host.stop();
      check("broadcast start", (n_cs_a - k0) + 2 * (n_cs_b - k1), 3);
      check("conv status", {host.rx_a[0], host.rx_b[0]}, 16'h0000);
      drive(1'b1, 1'b0, 1'b1);
      k0 = n_cs_a;
      k1 = n_cs_b;
      run({1'b1, address_pin_bits}, {2'b10, 9'($urandom)}, 0, 1'b1);
      k2 = n_iso;
      k3 = n_low;
      host.xfer(1);
      repeat (6) @(posedge clk_sys);
      check("iso busy", 16 * (n_iso - k2) + n_low - k3, 136);
      check("addressed start", (n_cs_a - k0) + 2 * (n_cs_b - k1), 1);
      drive(1'b0, 1'b0, 1'b1);
      k2 = n_iso;
      k3 = n_low;
      host.xfer(1);
      repeat (6) @(posedge clk_sys);
      host.stop();
      check("iso done", 16 * (n_iso - k2) + n_low - k3, 128);
      check("chain iso silent", n_isb, 0);
      k2 = n_iso;
      run(5'h00, {2'b11, 9'($urandom)}, 0, 1'b1);
      host.stop();
      check("iso exit", n_iso - k2, 0);
      drive(1'b0, 1'b0, 1'b0);
      for (int g = 1; g >= 0; g--) begin
         fill(4);
         if (g == 1) exp = packw(host.tx, 4);
         else host.tx[10] ^= 8'h01;
         k0 = n_wc_a;
         run({1'b1, address_pin_bits}, WR_CODE, 8, 1'b1);
         check("early commit", n_wc_a - k0, 0);
         host.stop();
         check("commit", n_wc_a - k0, g);
         check("write data", wd_a, exp);
      end
      fill(4);
      fill(12);
      ups.delete();
      k1 = n_wc_b;
      k0 = n_upa;
      run(5'h00, WR_CODE, 16, 1'b1);
      host.stop();
      check("chain count", ups.size(), 8);
      check("parallel up", n_upa - k0, 8);
      for (int i = 0; i < 8 && i < ups.size(); i++) check("chain up", ups[i], host.tx[4 + i]);
      check("chain commit", n_wc_b - k1, 1);
      check("chain data", wd_b, packw(host.tx, 12));
      check("parallel data", wd_a, packw(host.tx, 12));
      @(negedge clk_sys);
      read_data <= {16'($urandom), $urandom};
      other = address_pin_bits ^ 4'h6;
      for (int m = 1; m >= 0; m--) begin
         run({1'b1, m ? address_pin_bits : other}, RD_CODE, 8, 1'b1);
         host.stop();
         for (int i = 0; i < 6; i++) ex[i] = read_data[8*i +: 8];
         exp = pec_of(ex, 0, 6);
         check("read data", pack6(host.rx_a, 4), m ? read_data : '1);
         check("read check", {host.rx_a[10], host.rx_a[11]}, m ? exp[15:0] : 16'hFFFF);
         check("chain silent", pack6(host.rx_b, 4), '1);
      end
      held = 8'($urandom);
      fork
         run(5'h00, RD_CODE, 10, 1'b1);
         begin
            repeat (300) @(posedge clk_sys);
            @(negedge clk_sys);
            chain_down <= '{valid: 1'b1, data: held};
            @(negedge clk_sys);
            chain_down.valid <= 1'b0;
         end
      join
      host.stop();
      check("chain read", pack6(host.rx_b, 4), read_data);
      check("chain pass", host.rx_b[12], held);
      finish_test();
   end
endmodule
